// [rtl/imts_master_tx.sv]
`timescale 1ns/1ns
module imts_master_tx import imts_pkg::*; #(
  parameter logic [IMTS_CNT_W-1:0] QUARTER = IMTS_CNT_W'(IMTS_QUARTER_DEF)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Software side
  input wire logic start_req_set,
  input wire logic stop_req_set,
  input wire logic rstart_req_set,
  input wire logic buf_write,
  input wire logic [7:0] buf_wdata,
  input wire logic int_flag_clr,
  input wire logic write_collision_flag_clr,
  output logic start_request_bit,
  output logic stop_request_bit,
  output logic repeated_start_request_bit,
  output logic serial_port_int_flag,
  output logic ack_status_flag,
  output logic buffer_full_flag,
  output logic write_collision_flag,
  output logic [7:0] transmit_buffer,
  // Bus pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  imts_state_t st_q, st_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, buf_q, buf_d;
  logic sen_q, sen_d, pen_q, pen_d, repeated_start_request_bit_q, repeated_start_request_bit_d;
  logic int_q, int_d, ack_q, ack_d, bf_q, bf_d, write_collision_flag_q, write_collision_flag_d;
  logic scl_lo_q, scl_lo_d, sda_lo_q, sda_lo_d;
  logic tick, run, busy, ev_int, wr_ok;

  // Baud generator runs only while a condition or byte is in flight
  assign run = (st_q != IMTS_IDLE) && (st_q != IMTS_WAIT);
  imts_baud #(.QUARTER(QUARTER)) u_baud (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(run),
    .tick(tick)
  );

  assign busy = (st_q == IMTS_SHIFT);

  // Sequencer
  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    bit_d = bit_q;
    sh_d = sh_q;
    buf_d = buf_q;
    sen_d = sen_q | start_req_set;
    pen_d = pen_q | stop_req_set;
    repeated_start_request_bit_d = repeated_start_request_bit_q | rstart_req_set;
    ack_d = ack_q;
    bf_d = bf_q;
    scl_lo_d = scl_lo_q;
    sda_lo_d = sda_lo_q;
    ev_int = 1'b0;
    wr_ok = buf_write && !busy;
    write_collision_flag_d = (write_collision_flag_q && !write_collision_flag_clr) || (buf_write && busy); // (set wins)
    case (st_q)
      IMTS_IDLE: begin
        scl_lo_d = 1'b0;
        sda_lo_d = 1'b0;
        ph_d = '0;
        if (sen_q) begin
          st_d = IMTS_START;
        end
      end
      IMTS_START, IMTS_RSTART: begin
        // Restart first releases SDA with SCL low, then raises SCL
        if (tick) begin
          ph_d = ph_q + 1'b1;
          if (st_q == IMTS_RSTART && ph_q == '0) begin
            sda_lo_d = 1'b0;
          end else if (st_q == IMTS_RSTART && ph_q == IMTS_PH_MID) begin
            scl_lo_d = 1'b0;
          end else begin
            sda_lo_d = 1'b1; // SDA falls with SCL high
          end
          if (ph_q == IMTS_PH_LAST) begin
            ph_d = '0;
            st_d = IMTS_HOLD;
          end
        end
      end
      IMTS_HOLD: begin
        // Hold time before SCL is pulled low
        if (tick) begin
          ph_d = ph_q + 1'b1;
          if (ph_q == IMTS_HOLD_QUARTERS - 1'b1) begin
            scl_lo_d = 1'b1;
            ph_d = '0;
            sen_d = 1'b0;
            repeated_start_request_bit_d = 1'b0;
            ev_int = 1'b1;
            st_d = IMTS_WAIT;
          end
        end
      end
      IMTS_WAIT: begin
        // SCL held low; SDA stays low after a start and floats after a byte, until next request
        ph_d = '0;
        if (wr_ok) begin
          st_d = IMTS_SHIFT;
          sh_d = buf_wdata;
          bit_d = '0;
          sda_lo_d = !buf_wdata[IMTS_BYTE_BITS-1];
        end else if (pen_q) begin
          sda_lo_d = 1'b1;
          st_d = IMTS_STOP;
        end else if (repeated_start_request_bit_q) begin
          st_d = IMTS_RSTART;
        end
      end
      IMTS_SHIFT: begin
        if (tick) begin
          ph_d = ph_q + 1'b1;
          if (ph_q == IMTS_PH_MID) begin
            scl_lo_d = 1'b0;
          end else if (ph_q == IMTS_PH_LAST) begin
            scl_lo_d = 1'b1; // falling edge of SCL
            bit_d = bit_q + 1'b1;
            if (bit_q == IMTS_LAST_DATA_BIT) begin
              sda_lo_d = 1'b0; // release for acknowledge
              bf_d = 1'b0;
            end else if (bit_q == IMTS_ACK_BIT) begin
              ack_d = sda_in;
              ev_int = 1'b1;
              st_d = IMTS_WAIT;
            end else begin
              sh_d = {sh_q[IMTS_BYTE_BITS-2:0], 1'b0};
              sda_lo_d = !sh_q[IMTS_BYTE_BITS-2];
            end
          end
        end
      end
      IMTS_STOP: begin
        // SCL rises, then SDA rises with SCL high
        if (tick) begin
          ph_d = ph_q + 1'b1;
          if (ph_q == IMTS_PH_MID) begin
            scl_lo_d = 1'b0;
          end else if (ph_q == IMTS_PH_LAST) begin
            sda_lo_d = 1'b0;
            pen_d = 1'b0;
            ev_int = 1'b1;
            st_d = IMTS_IDLE;
          end
        end
      end
      default: st_d = IMTS_IDLE;
    endcase
    if (wr_ok) begin
      buf_d = buf_wdata;
      bf_d = 1'b1;
    end
    int_d = ev_int || (int_q && !int_flag_clr);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= IMTS_IDLE;
      ph_q <= '0;
      bit_q <= '0;
      sh_q <= '0;
      buf_q <= '0;
      sen_q <= 1'b0;
      pen_q <= 1'b0;
      repeated_start_request_bit_q <= 1'b0;
      int_q <= 1'b0;
      ack_q <= 1'b0;
      bf_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      scl_lo_q <= 1'b0;
      sda_lo_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      buf_q <= buf_d;
      sen_q <= sen_d;
      pen_q <= pen_d;
      repeated_start_request_bit_q <= repeated_start_request_bit_d;
      int_q <= int_d;
      ack_q <= ack_d;
      bf_q <= bf_d;
      write_collision_flag_q <= write_collision_flag_d;
      scl_lo_q <= scl_lo_d;
      sda_lo_q <= sda_lo_d;
    end
  end

  // Outputs straight from flops; open drain drives only low
  assign start_request_bit = sen_q;
  assign stop_request_bit = pen_q;
  assign repeated_start_request_bit = repeated_start_request_bit_q;
  assign serial_port_int_flag = int_q;
  assign ack_status_flag = ack_q;
  assign buffer_full_flag = bf_q;
  assign write_collision_flag = write_collision_flag_q;
  assign transmit_buffer = buf_q;
  assign scl_out = 1'b0;
  assign scl_oe = scl_lo_q;
  assign sda_out = 1'b0;
  assign sda_oe = sda_lo_q;
endmodule // imts_master_tx

// [rtl/imts_pkg.sv]
package imts_pkg;
  // Baud generator reload: quarter SCL period in sys_clk cycles, minus one
  localparam int unsigned IMTS_QUARTER_DEF = 63;
  localparam int unsigned IMTS_CNT_W = 8;
  // Bits per byte and the acknowledge slot index
  localparam int unsigned IMTS_BYTE_BITS = 8;
  localparam logic [3:0] IMTS_LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] IMTS_ACK_BIT = 4'h8;
  // Start hold wait, in baud quarters
  localparam logic [1:0] IMTS_HOLD_QUARTERS = 2'h3;
  // Phase of an SCL period, four quarters
  localparam logic [1:0] IMTS_PH_LAST = 2'h3;
  localparam logic [1:0] IMTS_PH_MID = 2'h1;

  typedef enum logic [3:0] {
    IMTS_IDLE, IMTS_START, IMTS_HOLD, IMTS_WAIT, IMTS_SHIFT,
    IMTS_STOP, IMTS_RSTART
  } imts_state_t;
endpackage

// [rtl/imts_baud.sv]
`timescale 1ns/1ns
// Quarter-period tick generator; stopped while idle so SCL can be held
module imts_baud import imts_pkg::*; #(
  parameter logic [IMTS_CNT_W-1:0] QUARTER = IMTS_CNT_W'(IMTS_QUARTER_DEF)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  output logic tick
);
  logic [IMTS_CNT_W-1:0] cnt_q, cnt_d;

  // Reload on expiry or while stopped
  always_comb begin
    tick = run && (cnt_q == '0);
    if (!run || cnt_q == '0) begin
      cnt_d = QUARTER;
    end else begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // imts_baud

// [verif/imts_slave_model.sv]
`timescale 1ns/1ns
// Slave on the bus: shifts bits in, acknowledges when told
module imts_slave_model (
  // Bus levels
  input wire logic scl,
  input wire logic sda,
  // Control and result
  input wire logic ack_en,
  output logic sda_oe,
  output logic [7:0] rx
);
  int k = 0;
  initial sda_oe = 1'b0;
  // Start resets the bit count
  always @(negedge sda) if (scl) k = 0;
  // Count clocks; only the eight data clocks are captured
  always @(posedge scl) begin
    k = (k == 9) ? 1 : k + 1;
    if (k <= 8) rx = {rx[6:0], sda};
  end
  // Pull SDA low through the ninth clock only
  always @(negedge scl) sda_oe = (k == 8) && ack_en;
endmodule // imts_slave_model

// [verif/imts_master_tx_monitor.sv]
`timescale 1ns/1ns
// Port checks for the transmit sequencer
module imts_master_tx_monitor import imts_pkg::*; #(
  parameter logic [IMTS_CNT_W-1:0] QUARTER = IMTS_CNT_W'(IMTS_QUARTER_DEF)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Watched ports
  input wire logic stop_req_set,
  input wire logic rstart_req_set,
  input wire logic buf_write,
  input wire logic [7:0] buf_wdata,
  input wire logic int_flag_clr,
  input wire logic start_request_bit,
  input wire logic stop_request_bit,
  input wire logic repeated_start_request_bit,
  input wire logic serial_port_int_flag,
  input wire logic buffer_full_flag,
  input wire logic write_collision_flag,
  input wire logic [7:0] transmit_buffer,
  input wire logic scl_oe,
  input wire logic sda_oe
);
  localparam int LIM = 4 * (int'(QUARTER) + 1) + 4;
  logic [10:0] stop_cnt_q;
  logic [10:0] stop_cnt_d;
  logic reqs;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Length of a pending stop, bounds its completion
  always_comb begin
    stop_cnt_d = stop_request_bit ? stop_cnt_q + 11'h1 : 11'h0;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) stop_cnt_q <= 11'h0;
    else stop_cnt_q <= stop_cnt_d;
  end
  assign reqs = start_request_bit | stop_request_bit | repeated_start_request_bit;
  sequence s_load;
    buf_write && serial_port_int_flag;
  endsequence
  chk_int_sticky: assert property (serial_port_int_flag && !int_flag_clr |=> serial_port_int_flag)
    else $error("int flag fell without clear");
  chk_load_takes: assert property (s_load |=> buffer_full_flag && transmit_buffer == $past(buf_wdata))
    else $error("buffer write not taken");
  chk_first_bit: assert property (s_load |=> sda_oe == !transmit_buffer[7])
    else $error("first bit not driven");
  chk_write_collision_flag_set: assert property (buf_write && buffer_full_flag |=> write_collision_flag
    && $stable(transmit_buffer))
    else $error("collision not flagged");
  chk_scl_parked: assert property (serial_port_int_flag && scl_oe && !buf_write && !reqs && !stop_req_set
    && !rstart_req_set |=> scl_oe)
    else $error("scl released while parked");
  chk_sda_on_low: assert property (!reqs && !$past(reqs) && $changed(sda_oe) |-> scl_oe)
    else $error("sda moved with scl high");
  chk_req_done: assert property ($rose(serial_port_int_flag) |-> ##[0:1] !reqs)
    else $error("request bit not cleared");
  chk_stop_bound: assert property (stop_cnt_q <= 11'(LIM))
    else $error("stop too long");
endmodule // imts_master_tx_monitor
bind imts_master_tx imts_master_tx_monitor #(.QUARTER(QUARTER)) i_mon (.sys_clk, .rst, .stop_req_set,
  .rstart_req_set, .buf_write, .buf_wdata, .int_flag_clr, .start_request_bit, .stop_request_bit,
  .repeated_start_request_bit, .serial_port_int_flag, .buffer_full_flag, .write_collision_flag,
  .transmit_buffer, .scl_oe, .sda_oe);

// [verif/imts_master_tx_tb.sv]
`timescale 1ns/1ns
// Directed run: start, address, collision, nack, restart, stop
module imts_master_tx_tb;
  logic sys_clk, rst, st, sp, rs, bw, ic, wc, ack_en, sb, pb, rb, ifl, ak, bf, wcl, scl_oe, sda_oe, so_oe;
  logic [7:0] wd, tbuf, rx;
  logic sclo, sdao;
  int n_fail = 0;
  int n_tests = 0;
  wire scl = !scl_oe;
  wire sda = !(sda_oe | so_oe);
  imts_master_tx #(.QUARTER(8'h2)) i_dut (.sys_clk, .rst, .start_req_set(st), .stop_req_set(sp),
    .rstart_req_set(rs), .buf_write(bw), .buf_wdata(wd), .int_flag_clr(ic), .write_collision_flag_clr(wc),
    .start_request_bit(sb), .stop_request_bit(pb), .repeated_start_request_bit(rb),
    .serial_port_int_flag(ifl), .ack_status_flag(ak), .buffer_full_flag(bf), .write_collision_flag(wcl),
    .transmit_buffer(tbuf), .scl_in(scl), .scl_out(sclo), .scl_oe, .sda_in(sda), .sda_out(sdao), .sda_oe);
  imts_slave_model i_slv (.scl, .sda, .ack_en, .sda_oe(so_oe), .rx);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = !sys_clk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("fails %0d tests %0d", n_fail, n_tests);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Request pulse, also clears the pending flag
  task req(input logic [2:0] r);
    @(posedge sys_clk);
    {st, sp, rs, ic} <= {r, 1'b1};
    @(posedge sys_clk);
    {st, sp, rs, ic} <= 4'h0;
  endtask
  // Buffer write; clears the flags in the same cycle
  task send(input logic [7:0] b);
    @(posedge sys_clk);
    {bw, ic, wc, wd} <= {3'h7, b};
    @(posedge sys_clk);
    {bw, ic, wc} <= 3'h0;
  endtask
  // Let the clear issued at the last edge settle before looking
  task wait_int;
    @(negedge sys_clk);
    for (int i = 0; i < 3000 && ifl !== 1'b1; i++) @(negedge sys_clk);
    if (ifl !== 1'b1) begin
      n_fail++;
      close_out;
    end
  endtask
  initial begin
    {rst, st, sp, rs, bw, ic, wc, ack_en, wd} = {8'h81, 8'h00};
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    req(3'h4);
    wait_int;
    chk(sb, 1'b0);
    send(8'ha6);
    send(8'hff);
    @(negedge sys_clk);
    chk(wcl, 1'b1);
    chk(tbuf, 8'ha6);
    chk(bf, 1'b1);
    wait_int;
    chk(ak, 1'b0);
    chk(rx, 8'ha6);
    chk(bf, 1'b0);
    ack_en = 1'b0;
    send(8'h35);
    wait_int;
    chk(ak, 1'b1);
    chk(rx, 8'h35);
    ack_en = 1'b1;
    req(3'h1);
    wait_int;
    chk(rb, 1'b0);
    send(8'h5c);
    wait_int;
    chk(ak, 1'b0);
    chk(rx, 8'h5c);
    req(3'h2);
    wait_int;
    chk(pb, 1'b0);
    chk({scl_oe, sda_oe}, 2'h0);
    chk({sclo, sdao}, 2'h0);
    close_out;
  end
endmodule // imts_master_tx_tb
